/* File: core/telemetry_map.vh */
// command codes, reset values and sample kinds of the telemetry bank
`ifndef TELEMETRY_MAP_VH
`define TELEMETRY_MAP_VH

// read-word command codes
`define CMD_VIN 8'h88
`define CMD_IIN 8'h89
`define CMD_VOUT 8'h8b
`define CMD_IOUT 8'h8c
`define CMD_TEXT 8'h8d
`define CMD_TINT 8'h8e
`define CMD_POUT 8'h96
`define CMD_PIN 8'h97
`define CMD_FINE_IOUT 8'hbb
`define CMD_IIN_MAX 8'hc4
`define CMD_IIN_LOW 8'hc5
`define CMD_PIN_MAX 8'hc6
`define CMD_PIN_LOW 8'hc7
`define CMD_IOUT_MAX 8'hd7
`define CMD_IOUT_LOW 8'hd8
`define CMD_VOUT_MAX 8'hdd
`define CMD_VIN_MAX 8'hde
`define CMD_TEXT_MAX 8'hdf
`define CMD_SENSE_DIFF 8'hfa
`define CMD_VOUT_LOW 8'hfb
`define CMD_VIN_LOW 8'hfc
`define CMD_TEXT_LOW 8'hfd

// reinitialisation values of the trackers, reset value of the readings
`define L11_MAX_INIT 16'h7c00
`define L11_LOW_INIT 16'h7bff
`define VOUT_MAX_INIT 16'hf800
`define VOUT_LOW_INIT 16'hffff
`define READING_INIT 16'h0000

// L11 field layout
`define L11_EXP_MSB 15
`define L11_EXP_LSB 11
`define L11_MANT_MSB 10
`define L11_EXP_MAX 6'sh0f
`define L11_EXP_MIN -6'sh10

// input current range: exponent drop per range step
`define IIN_RANGE_SHIFT 6'h01

// largest accepted diode ideality code
`define DIODE_IDEALITY_LIMIT 8'h80

// sample kinds on the adc result port
`define KIND_VIN 4'h0
`define KIND_IIN 4'h1
`define KIND_VOUT 4'h2
`define KIND_IOUT 4'h3
`define KIND_TEXT 4'h4
`define KIND_TINT 4'h5
`define KIND_POUT 4'h6
`define KIND_FINE_IOUT 4'h7
`define KIND_SENSE_DIFF 4'h8

`endif

/* File: core/telemetry_bank.v */
// read-only telemetry bank with running maxima and minima, two channels
//
// Summary of operation
// - input voltage read returns latest sample
// - input current scaled by range field
// - input power is current times voltage
// - output voltage read per page, L16
// - input current maximum, reinit 0x7c00
// - input current minimum, reinit 0x7bff
// - input power maximum, reinit 0x7c00
// - input power minimum, reinit 0x7bff
// - external temperature feeds all temperature use
// - internal temperature substitutes invalid external
// - invalid when pin stuck or ideality high
// - internal temperature otherwise affects nothing
// - fine output current read, 2.5mA lsb
// - sense differential read per page
// - unpaged input voltage running maximum
// - unpaged input voltage running minimum
// - paged output voltage maximum and minimum
// - paged output current maximum and minimum
// - paged external temperature maximum and minimum
// - paged output power read
// - output voltage maximum reinit 0xf800
`timescale 1ns/1ns
`default_nettype none
`include "telemetry_map.vh"

module telemetry_bank (
    input wire CLOCK_IN,
    input wire RST_N_IN,
    input wire CMD_READ_IN,
    input wire CMD_WRITE_IN,
    input wire [7:0] CMD_CODE_IN,
    input wire PAGE_IN,
    output reg [15:0] RD_DATA_OUT,
    output reg RD_VALID_OUT,
    output reg CMD_NACK_OUT,
    input wire SAMPLE_VALID_IN,
    input wire [3:0] SAMPLE_KIND_IN,
    input wire SAMPLE_CHAN_IN,
    input wire [15:0] SAMPLE_DATA_IN,
    input wire [1:0] IIN_RANGE_IN,
    input wire [1:0] TEMP_STUCK_IN,
    input wire [15:0] IDEALITY_IN,
    input wire [1:0] CLEAR_FAULTS_IN,
    input wire [1:0] CHAN_ON_IN
);

    ////////////////////////////////////////////////////////////////////////
    // L11 helpers

    // L11 word to signed fixed point, value times 2^16
    function signed [47:0] l11_key;
        input [15:0] w;
        reg signed [4:0] e;
        reg signed [47:0] m;
        begin
            e = w[`L11_EXP_MSB:`L11_EXP_LSB];
            m = {{37{w[`L11_MANT_MSB]}}, w[`L11_MANT_MSB:0]};
            l11_key = m <<< (e + 6'sd16);
        end
    endfunction

    // L11 product with renormalised mantissa, saturating exponent
    function [15:0] l11_mul;
        input [15:0] a;
        input [15:0] b;
        reg signed [21:0] p;
        reg signed [6:0] e;
        integer k;
        begin
            p = $signed(a[10:0]) * $signed(b[10:0]);
            e = $signed(a[15:11]) + $signed(b[15:11]);
            // normalise overflow and lift an underflowing exponent
            for (k = 0; k < 16; k = k + 1) begin
                if (p > 22'sd1023 || p < -22'sd1024 || e < -7'sd16) begin
                    p = p >>> 1;
                    e = e + 7'sd1;
                end
            end
            if (e > 7'sd15) begin
                l11_mul = p[21] ? `L11_MAX_INIT : `L11_LOW_INIT;
            end else begin
                l11_mul = {e[4:0], p[10:0]};
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // sample decode and clear events

    wire smp_vin = SAMPLE_VALID_IN && SAMPLE_KIND_IN == `KIND_VIN;
    wire smp_iin = SAMPLE_VALID_IN && SAMPLE_KIND_IN == `KIND_IIN;
    wire smp_tint = SAMPLE_VALID_IN && SAMPLE_KIND_IN == `KIND_TINT;

    reg [1:0] on_q;
    wire [1:0] turn_on = CHAN_ON_IN & ~on_q;
    // per page clear: clear-faults to it or its off-to-on edge
    wire [1:0] clr_page = CLEAR_FAULTS_IN | turn_on;
    // unpaged trackers clear on any page event
    wire clr_any = |clr_page;

    // remember previous channel enables for edge detection
    always @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            on_q <= 2'h0;
        end else begin
            on_q <= CHAN_ON_IN;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // unpaged input readings

    reg [15:0] vin_q, iin_q, pin_q, tint_q;
    reg pin_upd_q;
    wire [15:0] pin_d = l11_mul(iin_q, vin_q);

    // raw current lowered by range: exponent drops per step
    wire [5:0] iin_drop = {4'h0, IIN_RANGE_IN} * `IIN_RANGE_SHIFT;
    wire signed [5:0] iin_exp = $signed({SAMPLE_DATA_IN[15],
        SAMPLE_DATA_IN[15:11]}) - $signed(iin_drop);
    wire [15:0] iin_scaled = (iin_exp < `L11_EXP_MIN) ?
        {5'h10, SAMPLE_DATA_IN[10:0]} : {iin_exp[4:0], SAMPLE_DATA_IN[10:0]};

    // latest samples, power recomputed after either operand moves
    always @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            vin_q <= `READING_INIT;
            iin_q <= `READING_INIT;
            pin_q <= `READING_INIT;
            tint_q <= `READING_INIT;
            pin_upd_q <= 1'b0;
        end else begin
            if (smp_vin) begin
                vin_q <= SAMPLE_DATA_IN;
            end
            if (smp_iin) begin
                iin_q <= iin_scaled;
            end
            if (smp_tint) begin
                tint_q <= SAMPLE_DATA_IN; // also substitutes for an invalid external temperature
            end
            pin_upd_q <= smp_vin | smp_iin;
            if (pin_upd_q) begin
                pin_q <= pin_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // unpaged trackers

    reg [15:0] vin_max_q, vin_low_q, iin_max_q, iin_low_q;
    reg [15:0] pin_max_q, pin_low_q;

    // replace only on a strictly larger or smaller sample
    always @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            vin_max_q <= `L11_MAX_INIT;
            vin_low_q <= `L11_LOW_INIT;
            iin_max_q <= `L11_MAX_INIT;
            iin_low_q <= `L11_LOW_INIT;
            pin_max_q <= `L11_MAX_INIT;
            pin_low_q <= `L11_LOW_INIT;
        end else if (clr_any) begin
            vin_max_q <= `L11_MAX_INIT;
            vin_low_q <= `L11_LOW_INIT;
            iin_max_q <= `L11_MAX_INIT;
            iin_low_q <= `L11_LOW_INIT;
            pin_max_q <= `L11_MAX_INIT;
            pin_low_q <= `L11_LOW_INIT;
        end else begin
            if (smp_vin && l11_key(SAMPLE_DATA_IN) > l11_key(vin_max_q)) begin
                vin_max_q <= SAMPLE_DATA_IN;
            end
            if (smp_vin && l11_key(SAMPLE_DATA_IN) < l11_key(vin_low_q)) begin
                vin_low_q <= SAMPLE_DATA_IN;
            end
            if (smp_iin && l11_key(iin_scaled) > l11_key(iin_max_q)) begin
                iin_max_q <= iin_scaled;
            end
            if (smp_iin && l11_key(iin_scaled) < l11_key(iin_low_q)) begin
                iin_low_q <= iin_scaled;
            end
            if (pin_upd_q && l11_key(pin_d) > l11_key(pin_max_q)) begin
                pin_max_q <= pin_d;
            end
            if (pin_upd_q && l11_key(pin_d) < l11_key(pin_low_q)) begin
                pin_low_q <= pin_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // paged channel readings and trackers

    wire [31:0] vout_w, iout_w, temp_w, pout_w, fine_w, sense_w;
    wire [31:0] vout_max_w, vout_low_w, iout_max_w, iout_low_w;
    wire [31:0] temp_max_w, temp_low_w;

    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : chan
            reg [15:0] vout_q, iout_q, temp_q, pout_q, fine_q, sense_q;
            reg [15:0] vout_max_q, vout_low_q, iout_max_q, iout_low_q;
            reg [15:0] temp_max_q, temp_low_q;
            wire mine = SAMPLE_VALID_IN && SAMPLE_CHAN_IN == i;
            wire s_vout = mine && SAMPLE_KIND_IN == `KIND_VOUT;
            wire s_iout = mine && SAMPLE_KIND_IN == `KIND_IOUT;
            wire s_text = mine && SAMPLE_KIND_IN == `KIND_TEXT;
            // sense network valid unless stuck or diode too ideal-poor
            wire ext_ok = !TEMP_STUCK_IN[i] &&
                IDEALITY_IN[8*i+7:8*i] <= `DIODE_IDEALITY_LIMIT;
            // substitute: take internal value while external invalid
            wire t_upd = s_text | (smp_tint & ~ext_ok);
            wire [15:0] t_new = (s_text && ext_ok) ? SAMPLE_DATA_IN :
                (smp_tint ? SAMPLE_DATA_IN : tint_q);

            // latest per channel samples
            always @(posedge CLOCK_IN or negedge RST_N_IN) begin
                if (!RST_N_IN) begin
                    vout_q <= `READING_INIT;
                    iout_q <= `READING_INIT;
                    temp_q <= `READING_INIT;
                    pout_q <= `READING_INIT;
                    fine_q <= `READING_INIT;
                    sense_q <= `READING_INIT;
                end else begin
                    if (s_vout) begin
                        vout_q <= SAMPLE_DATA_IN;
                    end
                    if (s_iout) begin
                        iout_q <= SAMPLE_DATA_IN;
                    end
                    if (t_upd) begin
                        temp_q <= t_new;
                    end
                    if (mine && SAMPLE_KIND_IN == `KIND_POUT) begin
                        pout_q <= SAMPLE_DATA_IN;
                    end
                    if (mine && SAMPLE_KIND_IN == `KIND_FINE_IOUT) begin
                        fine_q <= SAMPLE_DATA_IN;
                    end
                    if (mine && SAMPLE_KIND_IN == `KIND_SENSE_DIFF) begin
                        sense_q <= SAMPLE_DATA_IN;
                    end
                end
            end

            // running extremes, cleared by this page's events
            always @(posedge CLOCK_IN or negedge RST_N_IN) begin
                if (!RST_N_IN) begin
                    vout_max_q <= `VOUT_MAX_INIT;
                    vout_low_q <= `VOUT_LOW_INIT;
                    iout_max_q <= `L11_MAX_INIT;
                    iout_low_q <= `L11_LOW_INIT;
                    temp_max_q <= `L11_MAX_INIT;
                    temp_low_q <= `L11_LOW_INIT;
                end else if (clr_page[i]) begin
                    vout_max_q <= `VOUT_MAX_INIT;
                    vout_low_q <= `VOUT_LOW_INIT;
                    iout_max_q <= `L11_MAX_INIT;
                    iout_low_q <= `L11_LOW_INIT;
                    temp_max_q <= `L11_MAX_INIT;
                    temp_low_q <= `L11_LOW_INIT;
                end else begin
                    // L16 unsigned; the max init code stands for zero
                    if (s_vout && (vout_max_q == `VOUT_MAX_INIT ||
                            SAMPLE_DATA_IN > vout_max_q)) begin
                        vout_max_q <= SAMPLE_DATA_IN;
                    end
                    if (s_vout && SAMPLE_DATA_IN < vout_low_q) begin
                        vout_low_q <= SAMPLE_DATA_IN;
                    end
                    if (s_iout && l11_key(SAMPLE_DATA_IN) >
                            l11_key(iout_max_q)) begin
                        iout_max_q <= SAMPLE_DATA_IN;
                    end
                    if (s_iout && l11_key(SAMPLE_DATA_IN) <
                            l11_key(iout_low_q)) begin
                        iout_low_q <= SAMPLE_DATA_IN;
                    end
                    if (t_upd && l11_key(t_new) > l11_key(temp_max_q)) begin
                        temp_max_q <= t_new;
                    end
                    if (t_upd && l11_key(t_new) < l11_key(temp_low_q)) begin
                        temp_low_q <= t_new;
                    end
                end
            end

            assign vout_w[16*i+15:16*i] = vout_q;
            assign iout_w[16*i+15:16*i] = iout_q;
            assign temp_w[16*i+15:16*i] = temp_q;
            assign pout_w[16*i+15:16*i] = pout_q;
            assign fine_w[16*i+15:16*i] = fine_q;
            assign sense_w[16*i+15:16*i] = sense_q;
            assign vout_max_w[16*i+15:16*i] = vout_max_q;
            assign vout_low_w[16*i+15:16*i] = vout_low_q;
            assign iout_max_w[16*i+15:16*i] = iout_max_q;
            assign iout_low_w[16*i+15:16*i] = iout_low_q;
            assign temp_max_w[16*i+15:16*i] = temp_max_q;
            assign temp_low_w[16*i+15:16*i] = temp_low_q;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // read-word decode

    wire [4:0] pg = {PAGE_IN, 4'h0};
    reg [15:0] rd_d;
    reg hit_d;

    // select the word for the command code and current page
    always @* begin
        hit_d = 1'b1;
        rd_d = 16'h0000;
        case (CMD_CODE_IN)
            `CMD_VIN: rd_d = vin_q;
            `CMD_IIN: rd_d = iin_q;
            `CMD_PIN: rd_d = pin_q;
            `CMD_VOUT: rd_d = vout_w[pg +: 16];
            `CMD_IOUT: rd_d = iout_w[pg +: 16];
            `CMD_TEXT: rd_d = temp_w[pg +: 16];
            `CMD_TINT: rd_d = tint_q;
            `CMD_POUT: rd_d = pout_w[pg +: 16];
            `CMD_FINE_IOUT: rd_d = fine_w[pg +: 16];
            `CMD_IIN_MAX: rd_d = iin_max_q;
            `CMD_IIN_LOW: rd_d = iin_low_q;
            `CMD_PIN_MAX: rd_d = pin_max_q;
            `CMD_PIN_LOW: rd_d = pin_low_q;
            `CMD_IOUT_MAX: rd_d = iout_max_w[pg +: 16];
            `CMD_IOUT_LOW: rd_d = iout_low_w[pg +: 16];
            `CMD_VOUT_MAX: rd_d = vout_max_w[pg +: 16];
            `CMD_VIN_MAX: rd_d = vin_max_q;
            `CMD_TEXT_MAX: rd_d = temp_max_w[pg +: 16];
            `CMD_SENSE_DIFF: rd_d = sense_w[pg +: 16];
            `CMD_VOUT_LOW: rd_d = vout_low_w[pg +: 16];
            `CMD_VIN_LOW: rd_d = vin_low_q;
            `CMD_TEXT_LOW: rd_d = temp_low_w[pg +: 16];
            default: hit_d = 1'b0;
        endcase
    end

    // answer one cycle after the request; writes and unknown read codes refused
    always @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            RD_DATA_OUT <= 16'h0000;
            RD_VALID_OUT <= 1'b0;
            CMD_NACK_OUT <= 1'b0;
        end else begin
            RD_VALID_OUT <= CMD_READ_IN && hit_d;
            CMD_NACK_OUT <= CMD_WRITE_IN || (CMD_READ_IN && !hit_d);
            if (CMD_READ_IN && hit_d) begin
                RD_DATA_OUT <= rd_d;
            end
        end
    end

endmodule
`default_nettype wire

/* File: testbench/pmbus_host_model.sv */
// host model issuing read-word requests and write attempts
`timescale 1ns/1ns
`default_nettype none
module pmbus_host_model (
    input wire logic clk_in,
    output logic rd_out,
    output logic wr_out,
    output logic [7:0] code_out,
    output logic page_out,
    input wire logic [15:0] data_in,
    input wire logic valid_in,
    input wire logic nack_in
);
    // idle request lines at time zero
    initial begin
        rd_out = 1'b0;
        wr_out = 1'b0;
        code_out = 8'h00;
        page_out = 1'b0;
    end
    // one command, answer taken while it stands, then release
    task automatic xfer(input logic wr, input logic [7:0] code,
        input logic page, output logic [15:0] d, output logic v,
        output logic n);
        @(negedge clk_in);
        rd_out = !wr;
        wr_out = wr;
        code_out = code;
        page_out = page;
        @(posedge clk_in);
        @(negedge clk_in);
        // answer stands for the one cycle after the taking edge
        d = data_in;
        v = valid_in;
        n = nack_in;
        // released lines show a changed pattern, not the last value
        rd_out = 1'b0;
        wr_out = 1'b0;
        code_out = ~code;
        page_out = ~page;
    endtask
endmodule
`default_nettype wire

/* File: testbench/telemetry_bank_asserts.sv */
// concurrent checks on the telemetry bank ports
`timescale 1ns/1ns
`default_nettype none
`include "telemetry_map.vh"
module telemetry_bank_asserts (
    input wire logic CLOCK_IN,
    input wire logic RST_N_IN,
    input wire logic CMD_READ_IN,
    input wire logic CMD_WRITE_IN,
    input wire logic [7:0] CMD_CODE_IN,
    input wire logic PAGE_IN,
    input wire logic [15:0] RD_DATA_OUT,
    input wire logic RD_VALID_OUT,
    input wire logic CMD_NACK_OUT,
    input wire logic SAMPLE_VALID_IN,
    input wire logic [3:0] SAMPLE_KIND_IN,
    input wire logic [15:0] SAMPLE_DATA_IN,
    input wire logic [1:0] CLEAR_FAULTS_IN,
    input wire logic [1:0] CHAN_ON_IN
);
    logic [15:0] vin_q;
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RST_N_IN);
    // shadow of the latest input voltage sample
    always @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            vin_q <= `READING_INIT;
        end else if (SAMPLE_VALID_IN && SAMPLE_KIND_IN == `KIND_VIN) begin
            vin_q <= SAMPLE_DATA_IN;
        end
    end
    ////////////////////////////////////////////////////////////////////
    property p_read_answer;
        CMD_READ_IN && !CMD_WRITE_IN |=> RD_VALID_OUT != CMD_NACK_OUT;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read got no single answer");
    property p_write_nack;
        CMD_WRITE_IN |=> CMD_NACK_OUT && !RD_VALID_OUT;
    endproperty
    a_write_nack: assert property (p_write_nack)
        else $error("write attempt not refused");
    property p_idle_quiet;
        !CMD_READ_IN && !CMD_WRITE_IN |=> !RD_VALID_OUT && !CMD_NACK_OUT;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("answer without request");
    property p_data_hold;
        !RD_VALID_OUT |-> $stable(RD_DATA_OUT);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("read word changed without a read");
    property p_vin_read;
        CMD_READ_IN && CMD_CODE_IN == `CMD_VIN
            |=> RD_VALID_OUT && RD_DATA_OUT == $past(vin_q);
    endproperty
    a_vin_read: assert property (p_vin_read)
        else $error("input voltage read not latest sample");
    property p_iin_max_clear;
        (CLEAR_FAULTS_IN != 2'b00) ##1 !SAMPLE_VALID_IN
            ##1 (CMD_READ_IN && CMD_CODE_IN == `CMD_IIN_MAX)
            |=> RD_DATA_OUT == `L11_MAX_INIT;
    endproperty
    a_iin_max_clear: assert property (p_iin_max_clear)
        else $error("input current max not reinitialised");
    property p_iin_low_clear;
        (CLEAR_FAULTS_IN != 2'b00) ##1 !SAMPLE_VALID_IN [*3]
            ##1 (CMD_READ_IN && CMD_CODE_IN == `CMD_IIN_LOW)
            |=> RD_DATA_OUT == `L11_LOW_INIT;
    endproperty
    a_iin_low_clear: assert property (p_iin_low_clear)
        else $error("input current min not reinitialised");
    property p_vout_max_on;
        $rose(CHAN_ON_IN[0])
            ##1 (CMD_READ_IN && CMD_CODE_IN == `CMD_VOUT_MAX && !PAGE_IN)
            |=> RD_DATA_OUT == `VOUT_MAX_INIT;
    endproperty
    a_vout_max_on: assert property (p_vout_max_on)
        else $error("output voltage max not reinitialised");
endmodule
bind telemetry_bank telemetry_bank_asserts i_telemetry_bank_asserts (
    .CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN), .CMD_READ_IN(CMD_READ_IN),
    .CMD_WRITE_IN(CMD_WRITE_IN), .CMD_CODE_IN(CMD_CODE_IN),
    .PAGE_IN(PAGE_IN), .RD_DATA_OUT(RD_DATA_OUT),
    .RD_VALID_OUT(RD_VALID_OUT), .CMD_NACK_OUT(CMD_NACK_OUT),
    .SAMPLE_VALID_IN(SAMPLE_VALID_IN), .SAMPLE_KIND_IN(SAMPLE_KIND_IN),
    .SAMPLE_DATA_IN(SAMPLE_DATA_IN), .CLEAR_FAULTS_IN(CLEAR_FAULTS_IN),
    .CHAN_ON_IN(CHAN_ON_IN));
`default_nettype wire

/* File: testbench/telemetry_bank_tb_top.sv */
// testbench for the telemetry bank
`timescale 1ns/1ns
`default_nettype none
`include "telemetry_map.vh"
module telemetry_bank_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rd, wr, page, valid, nack, sv, schan;
    logic [7:0] code;
    logic [15:0] data, sdata, ideal;
    logic [3:0] skind = 4'h0;
    logic [1:0] range = 2'h0;
    logic [1:0] stuck = 2'h0;
    logic [1:0] clr = 2'h0;
    logic [1:0] on = 2'h0;
    int n_fail = 0;
    int n_compared = 0;
    ////////////////////////////////////////////////////////////////////
    // 50 MHz clock
    always #10 clk = ~clk;
    telemetry_bank i_telemetry_bank (.CLOCK_IN(clk), .RST_N_IN(rst_n),
        .CMD_READ_IN(rd), .CMD_WRITE_IN(wr), .CMD_CODE_IN(code),
        .PAGE_IN(page), .RD_DATA_OUT(data), .RD_VALID_OUT(valid),
        .CMD_NACK_OUT(nack), .SAMPLE_VALID_IN(sv),
        .SAMPLE_KIND_IN(skind), .SAMPLE_CHAN_IN(schan),
        .SAMPLE_DATA_IN(sdata), .IIN_RANGE_IN(range),
        .TEMP_STUCK_IN(stuck), .IDEALITY_IN(ideal),
        .CLEAR_FAULTS_IN(clr), .CHAN_ON_IN(on));
    pmbus_host_model i_pmbus_host_model (.clk_in(clk), .rd_out(rd),
        .wr_out(wr), .code_out(code), .page_out(page), .data_in(data),
        .valid_in(valid), .nack_in(nack));
    ////////////////////////////////////////////////////////////////////
    // read one word and compare
    task automatic rd_chk(input logic [7:0] c, input logic p,
        input logic [15:0] e);
        logic [15:0] d;
        logic v, n;
        i_pmbus_host_model.xfer(1'b0, c, p, d, v, n);
        n_compared++;
        if (v !== 1'b1 || d !== e) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, d, e);
        end
    endtask
    // command that must be refused
    task automatic nack_chk(input logic w, input logic [7:0] c);
        logic [15:0] d;
        logic v, n;
        i_pmbus_host_model.xfer(w, c, 1'b0, d, v, n);
        n_compared++;
        if (n !== 1'b1 || v !== 1'b0) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, n, 1'b1);
        end
    endtask
    // one adc result pulse
    task automatic smp(input logic [3:0] k, input logic ch,
        input logic [15:0] dt);
        @(negedge clk);
        sv = 1'b1;
        skind = k;
        schan = ch;
        sdata = dt;
        @(negedge clk);
        sv = 1'b0;
        sdata = ~dt;
    endtask
    task automatic tally_and_finish;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    // watchdog
    initial begin
        #200000;
        n_fail++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        sv = 1'b0;
        schan = 1'b0;
        sdata = 16'h0000;
        ideal = 16'h0000;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        rd_chk(`CMD_IIN_MAX, 1'b0, `L11_MAX_INIT);
        rd_chk(`CMD_IIN_LOW, 1'b0, `L11_LOW_INIT);
        rd_chk(`CMD_PIN_MAX, 1'b0, `L11_MAX_INIT);
        rd_chk(`CMD_PIN_LOW, 1'b0, `L11_LOW_INIT);
        rd_chk(`CMD_VOUT_MAX, 1'b1, `VOUT_MAX_INIT);
        smp(`KIND_VIN, 1'b0, 16'h000c);
        smp(`KIND_VIN, 1'b1, 16'h000a);
        rd_chk(`CMD_VIN, 1'b1, 16'h000a);
        rd_chk(`CMD_VIN_MAX, 1'b0, 16'h000c);
        rd_chk(`CMD_VIN_LOW, 1'b1, 16'h000a);
        smp(`KIND_IIN, 1'b0, 16'h0002);
        rd_chk(`CMD_IIN, 1'b0, 16'h0002);
        rd_chk(`CMD_IIN_MAX, 1'b1, 16'h0002);
        rd_chk(`CMD_PIN, 1'b0, 16'h0014);
        rd_chk(`CMD_PIN_MAX, 1'b0, 16'h0014);
        range = 2'h1;
        smp(`KIND_IIN, 1'b0, 16'h0002);
        rd_chk(`CMD_IIN, 1'b0, 16'hf802);
        rd_chk(`CMD_IIN_LOW, 1'b0, 16'hf802);
        range = 2'h3;
        smp(`KIND_IIN, 1'b0, 16'h0002);
        rd_chk(`CMD_IIN, 1'b0, 16'he802);
        range = 2'h0;
        smp(`KIND_VOUT, 1'b1, 16'h1234);
        smp(`KIND_VOUT, 1'b1, 16'h1000);
        smp(`KIND_VOUT, 1'b0, 16'h0100);
        rd_chk(`CMD_VOUT, 1'b1, 16'h1000);
        rd_chk(`CMD_VOUT, 1'b0, 16'h0100);
        rd_chk(`CMD_VOUT_MAX, 1'b1, 16'h1234);
        rd_chk(`CMD_VOUT_LOW, 1'b1, 16'h1000);
        smp(`KIND_IOUT, 1'b0, 16'h0003);
        rd_chk(`CMD_IOUT, 1'b0, 16'h0003);
        rd_chk(`CMD_IOUT_MAX, 1'b0, 16'h0003);
        rd_chk(`CMD_IOUT_LOW, 1'b0, 16'h0003);
        smp(`KIND_POUT, 1'b1, 16'h0007);
        rd_chk(`CMD_POUT, 1'b1, 16'h0007);
        smp(`KIND_FINE_IOUT, 1'b0, 16'h0002);
        rd_chk(`CMD_FINE_IOUT, 1'b0, 16'h0002);
        smp(`KIND_SENSE_DIFF, 1'b1, 16'h01fa);
        rd_chk(`CMD_SENSE_DIFF, 1'b1, 16'h01fa);
        smp(`KIND_TEXT, 1'b0, 16'h0019);
        smp(`KIND_TINT, 1'b0, 16'h001e);
        rd_chk(`CMD_TEXT, 1'b0, 16'h0019);
        rd_chk(`CMD_TEXT_MAX, 1'b0, 16'h0019);
        rd_chk(`CMD_TEXT_LOW, 1'b0, 16'h0019);
        rd_chk(`CMD_TINT, 1'b1, 16'h001e);
        stuck = 2'h2;
        smp(`KIND_TEXT, 1'b1, 16'h0050);
        rd_chk(`CMD_TEXT, 1'b1, 16'h001e);
        ideal = 16'h0081;
        smp(`KIND_TEXT, 1'b0, 16'h0040);
        rd_chk(`CMD_TEXT, 1'b0, 16'h001e);
        smp(`KIND_TINT, 1'b0, 16'h0020);
        rd_chk(`CMD_TEXT, 1'b1, 16'h0020);
        rd_chk(`CMD_TEXT, 1'b0, 16'h0020);
        nack_chk(1'b1, `CMD_VIN);
        rd_chk(`CMD_VIN, 1'b0, 16'h000a);
        nack_chk(1'b0, 8'h00);
        @(negedge clk);
        clr = 2'h1;
        @(negedge clk);
        clr = 2'h0;
        rd_chk(`CMD_IIN_MAX, 1'b0, `L11_MAX_INIT);
        rd_chk(`CMD_IIN_LOW, 1'b1, `L11_LOW_INIT);
        rd_chk(`CMD_PIN_MAX, 1'b0, `L11_MAX_INIT);
        rd_chk(`CMD_VIN_MAX, 1'b0, `L11_MAX_INIT);
        rd_chk(`CMD_VOUT_MAX, 1'b1, 16'h1234);
        @(negedge clk);
        on = 2'h1;
        rd_chk(`CMD_VOUT_MAX, 1'b0, `VOUT_MAX_INIT);
        rd_chk(`CMD_PIN_LOW, 1'b0, `L11_LOW_INIT);
        tally_and_finish();
    end
endmodule
`default_nettype wire
